//--- inc/mcsb_pkg.sv
`default_nettype none

package mcsb_pkg;

	// ----------------------------------------------------------------
	// Register map, as register numbers on the plain register port.
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 12;
	localparam int          DATA_W          = 64;
	localparam logic [11:0] OFF_FLAGS_SAVE  = 12'h188;
	localparam logic [11:0] OFF_IP_SAVE     = 12'h189;
	localparam logic [11:0] OFF_MISC_STATUS = 12'h18A;
	localparam logic [11:0] OFF_RSVD_FIRST  = 12'h18B;
	localparam logic [11:0] OFF_RSVD_LAST   = 12'h18F;
	localparam logic [11:0] OFF_GPR8_SAVE   = 12'h190;
	localparam logic [11:0] OFF_GPR9_SAVE   = 12'h191;
	localparam logic [11:0] OFF_GPR10_SAVE  = 12'h192;

	// ----------------------------------------------------------------
	// Fields and reset values.
	// ----------------------------------------------------------------
	localparam int          MISC_DS_FAULT_BIT = 0;
	localparam int          LOW_HALF_W        = 32;
	localparam logic [63:0] SAVE_RESET        = 64'h0000000000000000;
	localparam logic        DS_FAULT_RESET    = 1'h0;
	localparam logic [63:0] UNMAPPED_READ     = 64'h0000000000000000;

	// ----------------------------------------------------------------
	// Save bank layout: flags, ip, gpr8, gpr9, gpr10.
	// ----------------------------------------------------------------
	localparam int          SAVE_SLOTS = 5;
	localparam logic [2:0]  SLOT_FLAGS = 3'h0;
	localparam logic [2:0]  SLOT_IP    = 3'h1;
	localparam logic [2:0]  SLOT_GPR8  = 3'h2;
	localparam logic [2:0]  SLOT_GPR9  = 3'h3;
	localparam logic [2:0]  SLOT_GPR10 = 3'h4;

	typedef enum logic [1:0] {
		MCSB_RUN      = 2'b00,
		MCSB_SIGNAL   = 2'b01,
		MCSB_SHUTDOWN = 2'b11
	} mcsb_run_state_t;

endpackage : mcsb_pkg

`default_nettype wire

//--- inc/mcsb_save_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mcsb_save_if #(
	parameter int SLOTS = 5,
	parameter int W     = 64
);
	logic                     capture;
	logic                     wide_mode;
	logic [SLOTS-1:0][W-1:0]  cap_data;
	logic [$clog2(SLOTS)-1:0] rd_slot;
	logic [W-1:0]             rd_data;

	modport bank (
		input  capture,
		input  wide_mode,
		input  cap_data,
		input  rd_slot,
		output rd_data
	);

	modport ctrl (
		output capture,
		output wide_mode,
		output cap_data,
		output rd_slot,
		input  rd_data
	);
endinterface : mcsb_save_if

`default_nettype wire

//--- logic/mcsb_save_bank.sv
`timescale 1ns/1ps
`default_nettype none

module mcsb_save_bank #(
	parameter int SLOTS = 5,
	parameter int W     = 64
) (
	input  wire logic  clk,
	input  wire logic  rst,
	mcsb_save_if.bank  sv
);

	// ----------------------------------------------------------------
	// Capture storage with a plain read mux.
	// ----------------------------------------------------------------
	// The read port is not registered here: the top registers the bus answer once.
	// That keeps the answer in the cycle after the strobe, so the master never waits.
	logic [SLOTS-1:0][W-1:0] mem_q;
	logic [W-1:0]            hi_mask;

	// Outside 64-bit mode the upper half is undefined; it is stored as zero so reads are repeatable.
	assign hi_mask = sv.wide_mode ? {W{1'b1}} : {{(W-mcsb_pkg::LOW_HALF_W){1'b0}}, {mcsb_pkg::LOW_HALF_W{1'b1}}};

	genvar g;
	generate
		for (g = 0; g < SLOTS; g++) begin : g_slot
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					mem_q[g] <= mcsb_pkg::SAVE_RESET;
				end else if (sv.capture) begin
					mem_q[g] <= sv.cap_data[g] & hi_mask;
				end
			end
		end
	endgenerate

	assign sv.rd_data = mem_q[sv.rd_slot];

endmodule : mcsb_save_bank

`default_nettype wire

//--- logic/mcsb_wide_valid.sv
`timescale 1ns/1ps
`default_nettype none

module mcsb_wide_valid (
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  capture,
	input  wire logic  wide_mode,
	output logic       gpr_valid_q
);

	// ----------------------------------------------------------------
	// Remembers whether the last capture was taken in 64-bit mode.
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gpr_valid_q <= 1'b0;
		end else if (capture) begin
			gpr_valid_q <= wide_mode;
		end
	end

endmodule : mcsb_wide_valid

`default_nettype wire

//--- logic/mcsb_top.sv
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - On a machine check, flags and instruction pointer are captured into 64-bit saves.
// - Outside 64-bit mode only the low 32 bits of those saves mean anything.
// - A debug-store page assist or fault sets bit 0 of the misc register.
// - After signalling that fault the processor enters shutdown, not execution.
// - General register 8 to 10 saves are valid only if captured in 64-bit mode.
// - General register 8 to 10 saves exist only with the 64-bit extension.
module mcsb_top #(
	parameter int  THREADS   = 2,
	parameter bit  HAS_WIDE  = 1'b1
) (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic [$clog2(THREADS)-1:0]    thread_sel,
	input  wire logic [mcsb_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [mcsb_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [mcsb_pkg::DATA_W-1:0]   reg_rdata,
	input  wire logic [THREADS-1:0]            mc_event,
	input  wire logic [THREADS-1:0]            wide_mode,
	input  wire logic [THREADS-1:0][63:0]      processor_flags_register,
	input  wire logic [THREADS-1:0][63:0]      instruction_pointer,
	input  wire logic [THREADS-1:0][63:0]      gpr8_value,
	input  wire logic [THREADS-1:0][63:0]      gpr9_value,
	input  wire logic [THREADS-1:0][63:0]      gpr10_value,
	input  wire logic [THREADS-1:0]            ds_fault_event,
	output logic      [THREADS-1:0]            shutdown_q
);

	// ----------------------------------------------------------------
	// Address decode, shared by all threads.
	// ----------------------------------------------------------------
	wire hit_flags = reg_addr == mcsb_pkg::OFF_FLAGS_SAVE;
	wire hit_ip    = reg_addr == mcsb_pkg::OFF_IP_SAVE;
	wire hit_misc  = reg_addr == mcsb_pkg::OFF_MISC_STATUS;
	wire hit_g8    = HAS_WIDE && reg_addr == mcsb_pkg::OFF_GPR8_SAVE;
	wire hit_g9    = HAS_WIDE && reg_addr == mcsb_pkg::OFF_GPR9_SAVE;
	wire hit_g10   = HAS_WIDE && reg_addr == mcsb_pkg::OFF_GPR10_SAVE;
	wire hit_save  = hit_flags | hit_ip | hit_g8 | hit_g9 | hit_g10;
	wire hit_gpr   = hit_g8 | hit_g9 | hit_g10;

	logic [2:0] slot_sel;
	assign slot_sel = hit_ip  ? mcsb_pkg::SLOT_IP   :
	                  hit_g8  ? mcsb_pkg::SLOT_GPR8 :
	                  hit_g9  ? mcsb_pkg::SLOT_GPR9 :
	                  hit_g10 ? mcsb_pkg::SLOT_GPR10 : mcsb_pkg::SLOT_FLAGS;

	// Apart from reset, a write of zero to bit 0 of the misc register is the only way to clear the fault flag.
	wire misc_clear = reg_wr && hit_misc && !reg_wdata[mcsb_pkg::MISC_DS_FAULT_BIT];

	// ----------------------------------------------------------------
	// Per-thread state, each thread private.
	// ----------------------------------------------------------------
	logic [THREADS-1:0][63:0] save_rd;
	logic [THREADS-1:0]       ds_fault_q;
	logic [THREADS-1:0]       gpr_valid;

	genvar t;
	generate
		for (t = 0; t < THREADS; t++) begin : g_thr
			mcsb_save_if #(.SLOTS(mcsb_pkg::SAVE_SLOTS), .W(64)) sv ();
			mcsb_pkg::mcsb_run_state_t st_q;
			mcsb_pkg::mcsb_run_state_t st_d;

			assign sv.capture     = mc_event[t];
			assign sv.wide_mode   = wide_mode[t];
			assign sv.cap_data[0] = processor_flags_register[t];
			assign sv.cap_data[1] = instruction_pointer[t];
			assign sv.cap_data[2] = gpr8_value[t];
			assign sv.cap_data[3] = gpr9_value[t];
			assign sv.cap_data[4] = gpr10_value[t];
			assign sv.rd_slot     = slot_sel;
			assign save_rd[t]     = sv.rd_data;

			mcsb_save_bank #(
				.SLOTS (mcsb_pkg::SAVE_SLOTS),
				.W     (64)
			) u_bank (
				.clk (clk),
				.rst (rst),
				.sv  (sv.bank)
			);

			mcsb_wide_valid u_valid (
				.clk         (clk),
				.rst         (rst),
				.capture     (mc_event[t]),
				.wide_mode   (wide_mode[t]),
				.gpr_valid_q (gpr_valid[t])
			);

			localparam int THR_W = $clog2(THREADS);
			wire my_clear = misc_clear && thread_sel == THR_W'(t);

			// A new fault in the clearing cycle wins, so no event is lost.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					ds_fault_q[t] <= mcsb_pkg::DS_FAULT_RESET;
				end else if (ds_fault_event[t]) begin
					ds_fault_q[t] <= 1'b1;
				end else if (my_clear) begin
					ds_fault_q[t] <= 1'b0;
				end
			end

			always_comb begin
				case (st_q)
					mcsb_pkg::MCSB_RUN:      st_d = ds_fault_event[t] ? mcsb_pkg::MCSB_SIGNAL : mcsb_pkg::MCSB_RUN;
					mcsb_pkg::MCSB_SIGNAL:   st_d = mcsb_pkg::MCSB_SHUTDOWN;
					mcsb_pkg::MCSB_SHUTDOWN: st_d = mcsb_pkg::MCSB_SHUTDOWN;
					default:                 st_d = mcsb_pkg::MCSB_RUN;
				endcase
			end

			// Shutdown is left only by reset, matching a processor that stops executing.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					st_q          <= mcsb_pkg::MCSB_RUN;
					shutdown_q[t] <= 1'b0;
				end else begin
					st_q          <= st_d;
					shutdown_q[t] <= st_d == mcsb_pkg::MCSB_SHUTDOWN;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read data mux; unmapped and reserved offsets read zero.
	// ----------------------------------------------------------------
	logic [63:0] rdata_d;
	always_comb begin
		rdata_d = mcsb_pkg::UNMAPPED_READ;
		if (hit_save && (!hit_gpr || gpr_valid[thread_sel])) begin
			rdata_d = save_rd[thread_sel];
		end else if (hit_misc) begin
			rdata_d[mcsb_pkg::MISC_DS_FAULT_BIT] = ds_fault_q[thread_sel];
		end
	end

	// This is the only read stage, so the answer stands in the cycle after the strobe.
	// A capture in the strobe cycle is not seen by that read; the next read shows it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= mcsb_pkg::UNMAPPED_READ;
		end else begin
			reg_rdata <= reg_rd ? rdata_d : mcsb_pkg::UNMAPPED_READ;
		end
	end

endmodule : mcsb_top

`default_nettype wire

//--- tb/mcsb_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module mcsb_top_props #(
	parameter int	THREADS		= 2,
	parameter bit	HAS_WIDE	= 1'b1
) (
	input wire logic			clk,
	input wire logic			rst,
	input wire logic [$clog2(THREADS)-1:0]	thread_sel,
	input wire logic [11:0]			reg_addr,
	input wire logic			reg_wr,
	input wire logic			reg_rd,
	input wire logic [63:0]			reg_rdata,
	input wire logic [THREADS-1:0]		mc_event,
	input wire logic [THREADS-1:0]		wide_mode,
	input wire logic [THREADS-1:0][63:0]	processor_flags_register,
	input wire logic [THREADS-1:0][63:0]	instruction_pointer,
	input wire logic [THREADS-1:0][63:0]	gpr9_value,
	input wire logic [THREADS-1:0]		ds_fault_event,
	input wire logic [THREADS-1:0]		shutdown_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Read of thread 0 with no capture racing it in the same cycle.
	sequence s_rd(a);
		reg_rd && reg_addr == a && thread_sel == '0 && !mc_event[0];
	endsequence
	property p_ip; mc_event[0] && wide_mode[0] ##1 s_rd(12'h189) |->
		##1 reg_rdata == $past(instruction_pointer[0], 2); endproperty
	a_ip: assert property (p_ip) else $error("ip save wrong");
	property p_narrow; mc_event[0] && !wide_mode[0] ##1 s_rd(12'h188) |->
		##1 reg_rdata[31:0] == $past(processor_flags_register[0][31:0], 2); endproperty
	a_narrow: assert property (p_narrow) else $error("flags low half wrong");
	property p_ds; ds_fault_event[0] ##1 !reg_wr ##1 s_rd(12'h18A) |-> ##1 reg_rdata[0]; endproperty
	a_ds: assert property (p_ds) else $error("fault bit not set");
	property p_shut; ds_fault_event[0] |-> ##2 shutdown_q[0]; endproperty
	a_shut: assert property (p_shut) else $error("no shutdown");
	property p_gnar; mc_event[0] && !wide_mode[0] ##1 s_rd(12'h190) |-> ##1 reg_rdata == 64'h0; endproperty
	a_gnar: assert property (p_gnar) else $error("gpr save not void");
	property p_gwide; mc_event[0] && wide_mode[0] ##1 s_rd(12'h191) |->
		##1 reg_rdata == $past(gpr9_value[0], 2); endproperty
	a_gwide: assert property (p_gwide) else $error("gpr save wrong");
	property p_priv; $rose(shutdown_q[1]) |-> $past(ds_fault_event[1], 2); endproperty
	a_priv: assert property (p_priv) else $error("thread 1 shutdown without cause");
endmodule : mcsb_top_props
bind mcsb_top mcsb_top_props #(.THREADS(THREADS), .HAS_WIDE(HAS_WIDE)) i_mcsb_top_props (.clk, .rst,
	.thread_sel, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .mc_event, .wide_mode,
	.processor_flags_register, .instruction_pointer, .gpr9_value, .ds_fault_event, .shutdown_q);
`default_nettype wire

//--- tb/mcsb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcsb_top_tb;
	logic			clk = 1'b0;
	logic			rst = 1'b1;
	logic [0:0]		thread_sel = '0;
	logic [11:0]		reg_addr = '0;
	logic [63:0]		reg_wdata = '0;
	logic			reg_wr = 1'b0;
	logic			reg_rd = 1'b0;
	logic [63:0]		reg_rdata;
	logic [1:0]		mc_event = '0;
	logic [1:0]		wide_mode = '0;
	logic [1:0]		ds_fault_event = '0;
	logic [1:0]		shutdown_q;
	logic [1:0][63:0]	fl = '0, ip = '0, g8 = '0, g9 = '0, g10 = '0;
	logic [63:0]		lf = 64'h1C;
	logic [63:0]		sv [2][5];
	logic [1:0]		flag = '0;
	logic [11:0]		adr [5] = '{12'h188, 12'h189, 12'h190, 12'h191, 12'h192};
	logic [11:0]		ra [9] = '{12'h188, 12'h189, 12'h18A, 12'h18B, 12'h18F, 12'h190, 12'h191, 12'h192, 12'h200};
	int			failures = 0;
	int			total_checks = 0;

	always #12.5 clk = ~clk;

	mcsb_top #(.THREADS(2), .HAS_WIDE(1'b1)) i_mcsb_top (.clk, .rst, .thread_sel, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .mc_event, .wide_mode, .processor_flags_register(fl),
		.instruction_pointer(ip), .gpr8_value(g8), .gpr9_value(g9), .gpr10_value(g10),
		.ds_fault_event, .shutdown_q);

	function automatic logic [63:0] nx(input logic [63:0] s);
		return {s[62:0], s[63] ^ s[62] ^ s[60] ^ s[59]};
	endfunction : nx

	// Model view of a register; unmapped and reserved offsets read zero.
	function automatic logic [63:0] ev(input int t, input logic [11:0] a);
		for (int s = 0; s < 5; s++)
			if (adr[s] == a) return sv[t][s];
		return a == 12'h18A ? {63'h0, flag[t]} : 64'h0;
	endfunction : ev

	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task rd(input int t, input logic [11:0] a);
		@(posedge clk);
		mc_event <= '0;
		thread_sel <= t[0];
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk($sformatf("rdata t%0d a%h", t, a), ev(t, a), reg_rdata);
	endtask : rd

	task wr(input int t, input logic [11:0] a, input logic [63:0] d);
		@(posedge clk);
		thread_sel <= t[0];
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		if (a == 12'h18A && !d[0]) flag[t] = 1'b0;
	endtask : wr

	// The other thread runs in the opposite mode so a mixed-up select shows.
	task cap(input int t, input bit w);
		logic [63:0] v [2][5];
		foreach (v[i, s]) begin
			lf = nx(lf);
			v[i][s] = lf;
		end
		for (int s = 0; s < 5; s++)
			sv[t][s] = w ? v[t][s] : (s < 2 ? {32'h0, v[t][s][31:0]} : 64'h0);
		@(posedge clk);
		wide_mode <= t ? {w, !w} : {!w, w};
		mc_event[t] <= 1'b1;
		fl <= {v[1][0], v[0][0]};
		ip <= {v[1][1], v[0][1]};
		g8 <= {v[1][2], v[0][2]};
		g9 <= {v[1][3], v[0][3]};
		g10 <= {v[1][4], v[0][4]};
	endtask : cap

	task fault(input int t);
		@(posedge clk);
		ds_fault_event[t] <= 1'b1;
		flag[t] = 1'b1;
		@(posedge clk);
		ds_fault_event <= '0;
	endtask : fault

	task test_done;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		test_done;
	end

	initial begin
		foreach (sv[i, s]) sv[i][s] = 64'h0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int t = 0; t < 2; t++)
			foreach (ra[i]) rd(t, ra[i]);
		chk("shutdown", 64'h0, {62'h0, shutdown_q});
		$display("reset values done");
		for (int m = 0; m < 4; m++)
			for (int s = 0; s < 5; s++) begin
				cap(m % 2, m[1]);
				rd(m % 2, adr[s]);
				rd(1 - m % 2, adr[s]);
			end
		$display("capture done");
		foreach (ra[i]) begin
			lf = nx(lf);
			wr(1, ra[i], lf | 64'h1);
			rd(1, ra[i]);
		end
		$display("write refusal done");
		fault(0);
		rd(0, 12'h18A);
		rd(1, 12'h18A);
		chk("shutdown", 64'h1, {62'h0, shutdown_q});
		wr(0, 12'h18A, 64'h1);
		repeat (20) @(posedge clk);
		rd(0, 12'h18A);
		wr(0, 12'h18A, 64'hFFFFFFFFFFFFFFFE);
		rd(0, 12'h18A);
		fault(1);
		rd(1, 12'h18A);
		chk("shutdown", 64'h3, {62'h0, shutdown_q});
		$display("fault done");
		test_done;
	end
endmodule : mcsb_top_tb
`default_nettype wire
